// *** core/esb_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module esb_core
   import esb_pkg::*;
#(
   parameter int SEG_W  = 8,
   parameter int PAGE_W = 10
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        class_b_trap,
   input  wire logic        periph_irq,
   input  wire logic        ext_irq,
   input  wire logic [9:0]  data_page_pointer,
   output logic             irq_lock,
   output logic             special_register_space_select,
   output logic             core_halted,
   output logic      [23:0] phys_addr,
   output logic      [4:0]  processor_status_word,
   output logic      [15:0] instruction_pointer
);

   logic [31:0]       instr_q;
   logic [15:0]       opnd_q;
   logic [15:0]       ip_q;
   logic [4:0]        psw_q;
   logic [2:0]        cnt_q;
   logic              seg_en_q;
   logic              page_en_q;
   logic              rng_q;
   logic [SEG_W-1:0]  seg_val_q;
   logic [PAGE_W-1:0] page_val_q;
   logic [15:0]       addr_q;
   logic              addr_long_q;
   logic [23:0]       phys_q;
   logic              lock_q;
   logic              ilg_q;
   logic              taken_q;
   esb_mode_e         mode_q;
   logic              ext_m_q;
   logic              ext_s_q;
   logic              pready_q;
   logic              pslverr_q;
   logic [31:0]       prdata_q;

   // apb decode
   wire setup   = psel & ~penable;
   wire wr_en   = psel & penable & pready_q & pwrite;
   wire sel_ins = (paddr == OFS_INSTR);
   wire sel_opn = (paddr == OFS_OPND);
   wire sel_ip  = (paddr == OFS_IP);
   wire sel_ctl = (paddr == OFS_CTRL);
   wire sel_sts = (paddr == OFS_STATUS);
   wire sel_adr = (paddr == OFS_ADDR);
   wire sel_psw = (paddr == OFS_PSW);
   wire mapped  = sel_ins | sel_opn | sel_ip | sel_ctl | sel_sts | sel_adr | sel_psw;

   // an execute strobe is refused while the core is halted
   wire exec    = wr_en & sel_ctl & pwdata[CTRL_EXEC] & (mode_q == ESB_RUN);
   wire psw_wr  = pwdata[CTRL_PSW_WR];

   // instruction decode
   wire [7:0] b0  = instr_q[7:0];
   wire [7:0] b1  = instr_q[15:8];
   wire [7:0] b2  = instr_q[23:16];
   wire [7:0] b3  = instr_q[31:24];
   wire [1:0] sub = b1[7:6];
   wire imm_seg   = (b0 == OP_EXT_IMM) & (b1[3:0] == 4'h0) & ~sub[0] & (b3 == 8'h00);
   wire imm_page  = (b0 == OP_EXT_IMM) & (b1[3:0] == 4'h0) & (sub == SUB_PAGE_RNG)
                    & (b3[7:2] == 6'h00);
   wire reg_ext   = (b0 == OP_EXT_REG) & (sub != SUB_PAGE);
   wire rng_only  = (b0 == OP_EXT_RNG) & (sub == SUB_SEG_RNG) & (b1[3:0] == 4'h0);
   wire bit_fmt   = (b3[3:0] == 4'h0);
   esb_dec_s dec;
   assign dec.ovr       = imm_seg | imm_page | reg_ext | rng_only;
   assign dec.seg       = (imm_seg | reg_ext) & ~sub[0];
   assign dec.page      = imm_page | (reg_ext & (sub == SUB_PAGE_RNG));
   assign dec.rng       = rng_only | ((imm_seg | imm_page | reg_ext) & sub[1]);
   assign dec.idle      = (instr_q == IDLE_CODE);
   assign dec.jb        = (b0 == OP_JB) & bit_fmt;
   assign dec.jump_if_bit_one_then_clear       = (b0 == OP_JBC) & bit_fmt;
   assign dec.ilg       = ~(dec.ovr | dec.idle | dec.jb | dec.jump_if_bit_one_then_clear);
   assign dec.short_len = reg_ext | rng_only;
   assign dec.cnt       = {1'b0, b1[5:4]} + 3'h1;

   // operands from immediate bytes or the word register value
   wire [SEG_W-1:0]  seg_src  = reg_ext ? opnd_q[SEG_W-1:0] : b2[SEG_W-1:0];
   wire [PAGE_W-1:0] page_src = reg_ext ? opnd_q[PAGE_W-1:0] : {b3[1:0], b2};

   // bit test and relative target
   wire [3:0]  bit_pos  = b3[7:4];
   wire        bit_val  = opnd_q[bit_pos];
   wire        taken    = (dec.jb | dec.jump_if_bit_one_then_clear) & bit_val;
   wire [15:0] ip_after = ip_q + (dec.short_len ? LEN_SHORT : LEN_LONG);
   wire [15:0] disp2    = {{7{b2[7]}}, b2, 1'b0};
   wire [15:0] target   = ip_after + disp2;
   wire [15:0] ip_d     = taken ? target : ip_after;

   // sequence counter; a class b trap beats everything
   wire       cnt_live = cnt_q != 3'h0;
   wire [2:0] cnt_d    = class_b_trap ? 3'h0 :
                         (exec & dec.ovr) ? dec.cnt :
                         (exec & cnt_live) ? cnt_q - 3'h1 : cnt_q;
   wire       seq_on   = cnt_d != 3'h0;
   wire       load     = exec & dec.ovr & ~class_b_trap;

   // flags
   logic [4:0] jbc_flags;
   always_comb begin
      jbc_flags        = 5'h00;
      jbc_flags[FLG_Z] = ~bit_val;
      jbc_flags[FLG_N] = bit_val;
   end
   wire [4:0] psw_d = (exec & psw_wr) ? pwdata[CTRL_PSW_LSB +: 5] :
                      (exec & dec.jump_if_bit_one_then_clear) ? jbc_flags : psw_q;

   // jbc write-back: clear the tested bit within the same step
   wire [15:0] bit_mask = 16'h0001 << bit_pos;
   wire [15:0] opnd_d   = (wr_en & sel_opn) ? pwdata[15:0] :
                          (exec & dec.jump_if_bit_one_then_clear & bit_val) ? (opnd_q & ~bit_mask) : opnd_q;

   // physical data address for long or indirect accesses
   wire [23:0] phys_d = ~addr_long_q ? {data_page_pointer, addr_q[13:0]} :
                        seg_en_q ? {seg_val_q, addr_q} :
                        page_en_q ? {page_val_q, addr_q[13:0]} :
                        {data_page_pointer, addr_q[13:0]};

   wire ext_wake = periph_irq | ext_s_q;

   wire [31:0] status = {20'h00000, taken_q, ilg_q, mode_q, lock_q, rng_q,
                         page_en_q, seg_en_q, 2'h0, cnt_q};
   wire [31:0] rd_mux = sel_ins ? instr_q :
                        sel_opn ? {16'h0000, opnd_q} :
                        sel_ip  ? {16'h0000, ip_q} :
                        sel_sts ? status :
                        sel_adr ? {8'h00, phys_q} :
                        sel_psw ? {27'h0000000, psw_q} : 32'h0000_0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q  <= (setup & ~pwrite) ? rd_mux : prdata_q;
      end
   end

   // external interrupt pin is asynchronous
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_m_q <= 1'b0;
         ext_s_q <= 1'b0;
      end else begin
         ext_m_q <= ext_irq;
         ext_s_q <= ext_m_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instr_q     <= 32'h0000_0000;
         opnd_q      <= 16'h0000;
         ip_q        <= IP_RST;
         psw_q       <= PSW_RST;
         addr_q      <= 16'h0000;
         addr_long_q <= 1'b0;
         phys_q      <= 24'h000000;
         ilg_q       <= 1'b0;
         taken_q     <= 1'b0;
      end else begin
         instr_q     <= (wr_en & sel_ins) ? pwdata : instr_q;
         opnd_q      <= opnd_d;
         ip_q        <= (wr_en & sel_ip) ? pwdata[15:0] : (exec ? ip_d : ip_q);
         psw_q       <= psw_d;
         addr_q      <= (wr_en & sel_adr) ? pwdata[15:0] : addr_q;
         addr_long_q <= (wr_en & sel_adr) ? pwdata[ADDR_LONG] : addr_long_q;
         phys_q      <= phys_d;
         ilg_q       <= exec ? dec.ilg : ilg_q;
         taken_q     <= exec ? taken : taken_q;
      end
   end

   // override state is live from the edge of the override itself
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q      <= CNT_RST;
         seg_en_q   <= 1'b0;
         page_en_q  <= 1'b0;
         rng_q      <= 1'b0;
         seg_val_q  <= '0;
         page_val_q <= '0;
         lock_q     <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         seg_en_q   <= load ? dec.seg : (seg_en_q & seq_on);
         page_en_q  <= load ? dec.page : (page_en_q & seq_on);
         rng_q      <= load ? dec.rng : (rng_q & seq_on);
         seg_val_q  <= load ? seg_src : seg_val_q;
         page_val_q <= load ? page_src : page_val_q;
         lock_q     <= seq_on;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= ESB_RUN;
      end else begin
         unique case (mode_q)
            ESB_RUN:  mode_q <= (exec & dec.idle) ? ESB_HALT : ESB_RUN;
            ESB_HALT: mode_q <= ext_wake ? ESB_RUN : ESB_HALT;
         endcase
      end
   end

   assign prdata                        = prdata_q;
   assign pready                        = pready_q;
   assign pslverr                       = pslverr_q;
   assign irq_lock                      = lock_q;
   assign special_register_space_select = rng_q;
   assign core_halted                   = mode_q;
   assign phys_addr                     = phys_q;
   assign processor_status_word         = psw_q;
   assign instruction_pointer           = ip_q;

   a_cnt_load: assert property (@(posedge clk) disable iff (rst)
      load |=> cnt_q == $past(dec.cnt))
      else $error("counter not loaded from count field");

   a_cnt_step: assert property (@(posedge clk) disable iff (rst)
      exec & ~dec.ovr & cnt_live & ~class_b_trap |=> cnt_q == $past(cnt_q) - 3'h1)
      else $error("counter did not step down");

   a_lock_seq: assert property (@(posedge clk) disable iff (rst)
      cnt_live |-> irq_lock)
      else $error("interrupts unlocked inside sequence");

   a_trapb_end: assert property (@(posedge clk) disable iff (rst)
      class_b_trap |=> cnt_q == 3'h0 && ~irq_lock && ~special_register_space_select)
      else $error("class b trap did not end sequence");

   a_seg_addr: assert property (@(posedge clk) disable iff (rst)
      seg_en_q & addr_long_q |=> phys_addr == {$past(seg_val_q), $past(addr_q)})
      else $error("segment not substituted");

   a_seg_next: assert property (@(posedge clk) disable iff (rst)
      load & dec.seg & dec.rng |=> seg_en_q & special_register_space_select)
      else $error("combined override not active next");

   a_jb_target: assert property (@(posedge clk) disable iff (rst)
      exec & dec.jb & bit_val |=> instruction_pointer == $past(target))
      else $error("bit jump target wrong");

   a_jbc_flags: assert property (@(posedge clk) disable iff (rst)
      exec & dec.jump_if_bit_one_then_clear & ~psw_wr |=>
         processor_status_word == {1'b0, ~$past(bit_val), 2'b00, $past(bit_val)})
      else $error("clear jump flags wrong");

   a_jbc_clear: assert property (@(posedge clk) disable iff (rst)
      exec & dec.jump_if_bit_one_then_clear & bit_val |=> opnd_q[$past(bit_pos)] == 1'b0)
      else $error("tested bit not cleared");

   a_flags_keep: assert property (@(posedge clk) disable iff (rst)
      exec & ~dec.jump_if_bit_one_then_clear & ~psw_wr |=> $stable(processor_status_word))
      else $error("flags changed by flag-neutral instruction");

   a_idle_hold: assert property (@(posedge clk) disable iff (rst)
      core_halted & ~periph_irq & ~ext_s_q |=> core_halted)
      else $error("halt left without interrupt");

   a_lock_load: assert property (@(posedge clk) disable iff (rst)
      load |=> irq_lock)
      else $error("sequence started without lock");

   a_lock_free: assert property (@(posedge clk) disable iff (rst)
      ~cnt_live |-> ~irq_lock)
      else $error("lock held with counter at zero");

   a_ovr_clear: assert property (@(posedge clk) disable iff (rst)
      ~cnt_live |-> ~special_register_space_select && ~seg_en_q && ~page_en_q)
      else $error("override left on with counter at zero");

   a_trap_wins: assert property (@(posedge clk) disable iff (rst)
      exec & dec.ovr & class_b_trap |=> cnt_q == 3'h0 && ~irq_lock)
      else $error("override loaded during class b trap");

   a_cnt_range: assert property (@(posedge clk) disable iff (rst)
      cnt_q <= 3'h4)
      else $error("counter beyond four");

   a_rng_load: assert property (@(posedge clk) disable iff (rst)
      load & dec.rng |=> special_register_space_select)
      else $error("range override not applied");

   a_page_addr: assert property (@(posedge clk) disable iff (rst)
      page_en_q & addr_long_q |=>
         phys_addr == {$past(page_val_q), $past(addr_q[13:0])})
      else $error("page not substituted");

   a_dpp_addr: assert property (@(posedge clk) disable iff (rst)
      ~seg_en_q & ~page_en_q |=>
         phys_addr == {$past(data_page_pointer), $past(addr_q[13:0])})
      else $error("normal data addressing not restored");

   a_seg_imm: assert property (@(posedge clk) disable iff (rst)
      exec & ~class_b_trap & (b0 == OP_EXT_IMM) & (sub == SUB_SEG) & (b1[3:0] == 4'h0)
         & (b3 == 8'h00) |=> seg_en_q && ~special_register_space_select
         && seg_val_q == $past(b2))
      else $error("immediate segment override misdecoded");

   a_rng_only: assert property (@(posedge clk) disable iff (rst)
      exec & ~class_b_trap & (b0 == OP_EXT_RNG) & (sub == SUB_SEG_RNG) & (b1[3:0] == 4'h0)
         |=> special_register_space_select && ~seg_en_q && ~page_en_q
         && cnt_q == {1'b0, $past(b1[5:4])} + 3'h1)
      else $error("range-only override misdecoded");

   a_page_imm: assert property (@(posedge clk) disable iff (rst)
      exec & ~class_b_trap & (b0 == OP_EXT_IMM) & (sub == SUB_PAGE_RNG) & (b1[3:0] == 4'h0)
         & (b3[7:2] == 6'h00) |=> page_en_q && special_register_space_select
         && page_val_q == $past({b3[1:0], b2}))
      else $error("immediate page override misdecoded");

   a_page_reg: assert property (@(posedge clk) disable iff (rst)
      exec & ~class_b_trap & (b0 == OP_EXT_REG) & (sub == SUB_PAGE_RNG) |=> page_en_q
         && special_register_space_select && page_val_q == $past(opnd_q[PAGE_W-1:0]))
      else $error("register page override misdecoded");

   a_seg_reg: assert property (@(posedge clk) disable iff (rst)
      exec & ~class_b_trap & (b0 == OP_EXT_REG) & (sub == SUB_SEG_RNG) |=> seg_en_q
         && special_register_space_select && seg_val_q == $past(opnd_q[SEG_W-1:0]))
      else $error("register segment override misdecoded");

   a_idle_enter: assert property (@(posedge clk) disable iff (rst)
      exec & (instr_q == IDLE_CODE) |=> core_halted)
      else $error("idle did not halt");

   // a near miss of the protected pattern must not stop the core
   a_idle_guard: assert property (@(posedge clk) disable iff (rst)
      exec & (instr_q != IDLE_CODE) |=> ~core_halted)
      else $error("halt without exact idle pattern");

   a_halt_refuse: assert property (@(posedge clk) disable iff (rst)
      core_halted & wr_en & sel_ctl |=>
         $stable(instruction_pointer) && $stable(processor_status_word))
      else $error("instruction executed while halted");

   a_wake_periph: assert property (@(posedge clk) disable iff (rst)
      core_halted & periph_irq |=> ~core_halted)
      else $error("peripheral interrupt did not wake");

   a_wake_ext: assert property (@(posedge clk) disable iff (rst)
      core_halted & ext_s_q |=> ~core_halted)
      else $error("external interrupt did not wake");

   a_jb_fall: assert property (@(posedge clk) disable iff (rst)
      exec & (dec.jb | dec.jump_if_bit_one_then_clear) & ~bit_val |=>
         instruction_pointer == $past(instruction_pointer) + 16'h0004)
      else $error("failed bit test did not fall through");

   a_jbc_target: assert property (@(posedge clk) disable iff (rst)
      exec & dec.jump_if_bit_one_then_clear & bit_val |=> instruction_pointer
         == $past(instruction_pointer) + 16'h0004 + {{7{$past(b2[7])}}, $past(b2), 1'b0})
      else $error("clear jump target wrong");

   a_jbc_others: assert property (@(posedge clk) disable iff (rst)
      exec & dec.jump_if_bit_one_then_clear |=> (opnd_q | $past(bit_mask)) == ($past(opnd_q) | $past(bit_mask)))
      else $error("clear jump touched other bits");

   a_psw_explicit: assert property (@(posedge clk) disable iff (rst)
      exec & psw_wr |=> processor_status_word == $past(pwdata[CTRL_PSW_LSB +: 5]))
      else $error("explicit status write lost");

   // zero wait states: the access cycle always carries the answer
   a_apb_ready: assert property (@(posedge clk) disable iff (rst)
      setup |=> pready && pslverr == ~$past(mapped))
      else $error("bus answer not in access cycle");

endmodule
`default_nettype wire

// *** common/esb_pkg.sv ***
// Overview of operation
// - override loads counter with count field plus one, decrements per covered instruction
// - while counter runs, interrupts, event transfers and class A traps stay locked
// - zero count or class B trap clears counter and overrides and unlocks on the same edge
// - range override steers register and bit accesses to extended space
// - segment override takes A23-A16 from segment, A15-A0 from address
// - segment overrides act on the very next instruction, no gap needed
// - combined segment-and-range override applies both for the same sequence
// - page-and-range override: 4-byte immediate sub-code 11, 2-byte register form
// - range-only override: 2-byte, sub-code 10, count in second byte
// - segment override: 4-byte immediate sub-code 00, 2-byte register form
// - segment-and-range override: 4-byte immediate sub-code 10, 2-byte register form
// - idle is a protected 4-byte redundant pattern that halts the core
// - halt lasts until peripheral or external interrupt; peripherals keep running
// - bit-one jump adds twice sign-extended word displacement when bit is one
// - jump base is the following instruction; failing test falls through
// - bit-one jump decodes as 4 bytes: word, displacement, bit position
// - bit-one-then-clear jump clears bit and branches indivisibly
// - clear jump always updates flags; explicit status write wins
// - clear jump sets zero to inverted bit, negative to bit, others cleared
// - page override takes A23-A14 from page, A13-A0 from address
// - clear jump decodes as leading byte AA, word, displacement, bit position
`default_nettype none
package esb_pkg;

   localparam logic [7:0]  OFS_INSTR  = 8'h00;
   localparam logic [7:0]  OFS_OPND   = 8'h04;
   localparam logic [7:0]  OFS_IP     = 8'h08;
   localparam logic [7:0]  OFS_CTRL   = 8'h0C;
   localparam logic [7:0]  OFS_STATUS = 8'h10;
   localparam logic [7:0]  OFS_ADDR   = 8'h14;
   localparam logic [7:0]  OFS_PSW    = 8'h18;

   localparam logic [7:0]  OP_EXT_IMM = 8'hD7;
   localparam logic [7:0]  OP_EXT_REG = 8'hDC;
   localparam logic [7:0]  OP_EXT_RNG = 8'hD1;
   localparam logic [7:0]  OP_JB      = 8'h8A;
   localparam logic [7:0]  OP_JBC     = 8'hAA;
   localparam logic [31:0] IDLE_CODE  = 32'h8787_7887;

   localparam logic [1:0]  SUB_SEG      = 2'h0;
   localparam logic [1:0]  SUB_PAGE     = 2'h1;
   localparam logic [1:0]  SUB_SEG_RNG  = 2'h2;
   localparam logic [1:0]  SUB_PAGE_RNG = 2'h3;

   localparam int          FLG_N = 0;
   localparam int          FLG_C = 1;
   localparam int          FLG_V = 2;
   localparam int          FLG_Z = 3;
   localparam int          FLG_E = 4;

   localparam int          CTRL_EXEC    = 0;
   localparam int          CTRL_PSW_WR  = 1;
   localparam int          CTRL_PSW_LSB = 8;
   localparam int          ADDR_LONG    = 16;

   localparam logic [2:0]  CNT_RST   = 3'h0;
   localparam logic [4:0]  PSW_RST   = 5'h00;
   localparam logic [15:0] IP_RST    = 16'h0000;
   localparam logic [15:0] LEN_SHORT = 16'h0002;
   localparam logic [15:0] LEN_LONG  = 16'h0004;

   typedef enum logic {
      ESB_RUN  = 1'b0,
      ESB_HALT = 1'b1
   } esb_mode_e;

   typedef struct packed {
      logic       ovr;
      logic       seg;
      logic       page;
      logic       rng;
      logic       idle;
      logic       jb;
      logic       jump_if_bit_one_then_clear;
      logic       ilg;
      logic       short_len;
      logic [2:0] cnt;
   } esb_dec_s;

endpackage
`default_nettype wire

// *** bench/esb_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module esb_core_test
   import esb_pkg::*;
;
   localparam logic [9:0]  DATA_PAGE_POINTER  = 10'h155;
   localparam logic [31:0] JB_F = {8'h50, 8'h02, 8'h00, OP_JB};
   logic        clk, rst, psel, penable, pwrite, class_b_trap, periph_irq, ext_irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er, irq_lock, special_register_space_select, core_halted;
   logic [9:0]  data_page_pointer;
   logic [23:0] phys_addr;
   logic [4:0]  processor_status_word, p;
   logic [15:0] instruction_pointer, eip, hip;
   int          err_count, compares;

   esb_core esb_core_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .class_b_trap(class_b_trap), .periph_irq(periph_irq), .ext_irq(ext_irq),
      .data_page_pointer(data_page_pointer), .irq_lock(irq_lock),
      .special_register_space_select(special_register_space_select),
      .core_halted(core_halted), .phys_addr(phys_addr),
      .processor_status_word(processor_status_word), .instruction_pointer(instruction_pointer));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic stop_test();
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // result visible two edges after the execute strobe lands
   task automatic ex(input logic [31:0] i, input logic [31:0] c);
      apb(1'b1, OFS_INSTR, i);
      apb(1'b1, OFS_CTRL, c);
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic ipc(input logic [15:0] s);
      eip = eip + s;
      chk(instruction_pointer, eip);
   endtask

   task automatic t_reset();
      #1;
      chk({irq_lock, special_register_space_select, core_halted}, 0);
      chk(processor_status_word, PSW_RST);
      chk(instruction_pointer, IP_RST);
      apb(1'b0, 8'h1C, 0);
      chk(er, 1);
      chk(rd, 0);
      apb(1'b1, OFS_PSW, 32'h1F);
      apb(1'b1, OFS_OPND, 0);
      apb(1'b1, OFS_IP, 32'h0100);
      eip = 16'h0100;
      apb(1'b1, OFS_ADDR, 32'h0001_1234);
      repeat (2) @(posedge clk);
      #1;
      chk(processor_status_word, PSW_RST);
      chk(phys_addr, {DATA_PAGE_POINTER, 14'h1234});
   endtask

   // count field plus one instructions stay covered, then all clears
   task automatic t_ovr(input logic [31:0] i, input logic es, input logic [23:0] ep,
                        input logic [15:0] st, input logic pc);
      int k;
      ex(i, 1);
      ipc(st);
      for (k = int'(i[13:12]) + 1; k > 0; k--) begin
         apb(1'b0, OFS_STATUS, 0);
         chk(rd[2:0], 32'(k));
         chk(irq_lock, 1);
         chk(special_register_space_select, es);
         if (pc)
            chk(phys_addr, ep);
         chk(processor_status_word, PSW_RST);
         ex(JB_F, 1);
         ipc(4);
      end
      chk({irq_lock, special_register_space_select}, 0);
      chk(phys_addr, {DATA_PAGE_POINTER, 14'h1234});
   endtask

   task automatic t_trap();
      ex({8'h00, 8'hC3, 8'hB0, OP_EXT_IMM}, 1);
      ipc(4);
      chk({irq_lock, special_register_space_select}, 2'b11);
      @(posedge clk);
      class_b_trap <= 1'b1;
      @(posedge clk);
      class_b_trap <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({irq_lock, special_register_space_select}, 0);
      chk(phys_addr, {DATA_PAGE_POINTER, 14'h1234});
      apb(1'b0, OFS_STATUS, 0);
      chk(rd[2:0], 0);
   endtask

   task automatic t_jump();
      apb(1'b1, OFS_OPND, 32'h0010);
      ex({8'h40, 8'hFE, 8'h00, OP_JB}, 1);
      ipc(16'h0000);
      apb(1'b0, OFS_STATUS, 0);
      chk(rd[11], 1);
      chk(processor_status_word, PSW_RST);
      ex({8'h40, 8'h05, 8'h00, OP_JB}, 32'h1F03);
      ipc(16'h000E);
      chk(processor_status_word, 5'h1F);
      ex({8'h40, 8'h03, 8'h00, OP_JBC}, 1);
      ipc(16'h000A);
      chk(processor_status_word, 5'h01);
      apb(1'b0, OFS_OPND, 0);
      chk(rd[15:0], 0);
      ex({8'h40, 8'h03, 8'h00, OP_JBC}, 1);
      ipc(16'h0004);
      apb(1'b0, OFS_STATUS, 0);
      chk(rd[11], 0);
      chk(processor_status_word, 5'h08);
      apb(1'b1, OFS_OPND, 32'h8000);
      ex({8'hF0, 8'h80, 8'h00, OP_JBC}, 32'h0A03);
      ipc(16'hFF04);
      chk(processor_status_word, 5'h0A);
      apb(1'b0, OFS_OPND, 0);
      chk(rd[15:0], 0);
   endtask

   task automatic wake(input logic ext);
      int n;
      n = 0;
      @(posedge clk);
      if (ext)
         ext_irq <= 1'b1;
      else
         periph_irq <= 1'b1;
      while (core_halted === 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      ext_irq <= 1'b0;
      periph_irq <= 1'b0;
      chk(core_halted, 0);
   endtask

   task automatic t_idle();
      int w;
      p = processor_status_word;
      ex(32'h8787_7787, 1);
      chk(core_halted, 0);
      apb(1'b0, OFS_STATUS, 0);
      chk(rd[10], 1);
      for (w = 0; w < 2; w++) begin
         ex(IDLE_CODE, 1);
         chk(core_halted, 1);
         chk(processor_status_word, p);
         hip = instruction_pointer;
         ex(JB_F, 1);
         repeat (5) @(posedge clk);
         // still asleep: the execute request was dropped
         chk({core_halted, instruction_pointer}, {1'b1, hip});
         wake(w[0]);
      end
   endtask

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, class_b_trap, periph_irq, ext_irq} = 0;
      paddr = 0;
      pwdata = 0;
      data_page_pointer = DATA_PAGE_POINTER;
      err_count = 0;
      compares = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ovr({8'h00, 8'h5A, 8'h10, OP_EXT_IMM}, 0, {8'h5A, 16'h1234}, 4, 1);
      t_ovr({16'h0, 8'hB0, OP_EXT_RNG}, 1, {DATA_PAGE_POINTER, 14'h1234}, 2, 1);
      t_ovr({8'h00, 8'hC3, 8'h80, OP_EXT_IMM}, 1, {8'hC3, 16'h1234}, 4, 1);
      t_ovr({8'h02, 8'hA5, 8'hC0, OP_EXT_IMM}, 1, {10'h2A5, 14'h1234}, 4, 1);
      t_ovr({16'h0, 8'h20, OP_EXT_REG}, 0, {8'h00, 16'h1234}, 2, 1);
      t_ovr({16'h0, 8'hB0, OP_EXT_REG}, 1, {8'h00, 16'h1234}, 2, 1);
      t_ovr({16'h0, 8'hC0, OP_EXT_REG}, 1, {10'h000, 14'h1234}, 2, 1);
      t_trap();
      t_jump();
      t_idle();
      stop_test();
   end
endmodule
`default_nettype wire
